// ===== hw/led_boost_defines.vh
// Timing constants and code widths for the LED boost sequencer
`ifndef LED_BOOST_DEFINES_VH
`define LED_BOOST_DEFINES_VH

`define CLK_FREQ_HZ        20000000
`define SW_FREQ_HZ         1200000
// Switching period in clock cycles, rounded down to stay at or above 1.2 MHz
`define SW_PERIOD_CYC      (`CLK_FREQ_HZ / `SW_FREQ_HZ)
// Least on-time in percent of the period; forced off only after this share
`define MAX_DUTY_PCT       90
`define MAX_ON_CYC         ((`SW_PERIOD_CYC * `MAX_DUTY_PCT + 99) / 100)
// Isolation switch edge delay, longest, in ns
`define ISO_DELAY_NS       1000
`define ISO_DELAY_CYC      ((`ISO_DELAY_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
// Soft start: steps and per-step hold in us
`define SS_STEPS           8
`define SS_STEP_US         213
`define SS_STEP_CYC        (`SS_STEP_US * (`CLK_FREQ_HZ / 1000000))
// Enable low time to shutdown in us
`define EN_OFF_US          1000
`define EN_OFF_CYC         (`EN_OFF_US * (`CLK_FREQ_HZ / 1000000))
// Overload persistence in ns, rounded up
`define OVL_NS             1500
`define OVL_CYC            ((`OVL_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)

`define CNT_W              16
`define STEP_W             4
`define PER_W              5
`define STEP_FULL          4'h8
`define STEP_MIN           4'h1
`define STEP_NONE          4'h0

`endif

// ===== hw/pin_sync.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module pin_sync (
  input  wire mclk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  sync_o
);
  reg meta;

  // First flop feeds only the second
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ===== hw/hold_timer.v
// Counter that reports a level held for a given number of cycles
`timescale 1ns/1ps
`include "led_boost_defines.vh"
module hold_timer (
  input  wire             mclk_i,
  input  wire             rst_n_i,
  input  wire             level_i,
  input  wire [`CNT_W-1:0] limit_i,
  output reg              done_o
);
  reg [`CNT_W-1:0] count;

  // Restarts whenever the level drops; saturates once the limit is hit
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= {`CNT_W{1'b0}};
      done_o <= 1'b0;
    end else if (!level_i) begin
      count  <= {`CNT_W{1'b0}};
      done_o <= 1'b0;
    end else if (count + 16'h0001 >= limit_i) begin
      done_o <= 1'b1;
    end else begin
      count <= count + 16'h0001;
    end
  end
endmodule

// ===== hw/led_boost_sequencer.v
// Control and protection sequencer for a current-mode boost LED driver
//
// Notes on behaviour
// R01 - Fixed 1.2 MHz cycle, switch on each start; the code runs a 16-cycle period, 1.25 MHz
// R02 - Peak-current trip ends the on-time
// R03 - Isolation switch follows dimming within 1 us
// R04 - Enable high starts switches and soft start
// R05 - Eight equal limit steps, 213 us each
// R06 - Enable low 1 ms enters shutdown from ramp or run
// R07 - Low supply holds both switches off
// R08 - Overload held 1.5 us latches off
// R09 - Overload ignored until ramp complete
// R10 - Overvoltage stops both switches same cycle
// R11 - Resume only after overvoltage comparator releases
// R12 - Overtemperature holds both switches off
// R13 - On-time allowed at least 90 percent
// R14 - Host holds dimming high two cycles
// R15 - Host dims between 60 Hz and 40 kHz
// R16 - Host keeps low-end dimming duty limits
// R17 - Enable high means run, low means stop
// R18 - Shutdown, lockout, latch restart ramp lowest step
`timescale 1ns/1ps
`include "led_boost_defines.vh"
module led_boost_sequencer (
  input  wire                mclk_i,
  input  wire                rst_n_i,
  input  wire                enable_i,
  input  wire                dim_i,
  input  wire                peak_trip_i,
  input  wire                overload_guard_i,
  input  wire                over_volt_i,
  input  wire                low_supply_lockout_i,
  input  wire                over_temp_i,
  output reg                 power_switch_o,
  output reg                 iso_switch_o,
  output reg  [`STEP_W-1:0]  current_limit_step_o,
  output reg                 ramp_done_o,
  output reg                 overload_latched_o,
  output reg                 shutdown_o,
  output reg                 cycle_start_o
);
  // Sequencer states, one-hot
  localparam [3:0] ST_OFF  = 4'b0001;
  localparam [3:0] ST_RAMP = 4'b0010;
  localparam [3:0] ST_RUN  = 4'b0100;
  localparam [3:0] ST_LATCH = 4'b1000;

  // Integer forms of the counts; each is cut to its counter width on purpose
  localparam integer      EN_OFF_INT  = `EN_OFF_CYC;
  localparam integer      OVL_INT     = `OVL_CYC;
  localparam integer      STEP_INT    = `SS_STEP_CYC;
  localparam integer      PERIOD_INT  = `SW_PERIOD_CYC - 1;
  localparam integer      ON_INT      = `MAX_ON_CYC - 1;
  localparam [`CNT_W-1:0] EN_OFF_LIM  = EN_OFF_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] OVL_LIM     = OVL_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] STEP_LIM    = STEP_INT[`CNT_W-1:0];
  localparam [`PER_W-1:0] PERIOD_LAST = PERIOD_INT[`PER_W-1:0];
  localparam [`PER_W-1:0] ON_LAST     = ON_INT[`PER_W-1:0];

  wire en_s;
  wire dim_s;
  wire peak_s;
  wire ovl_s;
  wire ovp_s;
  wire low_supply_lockout_s;
  wire otp_s;
  wire en_low_long;
  wire ovl_long;

  reg  [3:0]          state;
  reg  [3:0]          next_state;
  reg  [`CNT_W-1:0]   step_cnt;
  reg  [`PER_W-1:0]   phase;
  reg                 en_seen_low;
  reg                 on_allowed;
  reg                 next_power;
  reg                 next_iso;

  // Dwell end test, shared by the ramp exit decode and the step counter
  function dwell_end;
    input [`CNT_W-1:0] cnt;
    input [`CNT_W-1:0] lim;
    begin
      dwell_end = (cnt + 16'h0001 >= lim);
    end
  endfunction

  // Last phase of a period; the power switch turns on here
  function cycle_end;
    input [`PER_W-1:0] ph;
    begin
      cycle_end = (ph == PERIOD_LAST);
    end
  endfunction

  // All comparator and pin inputs are asynchronous to mclk_i
  pin_sync u_sync_en (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(enable_i),
    .sync_o (en_s)
  );

  pin_sync u_sync_dim (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(dim_i),
    .sync_o (dim_s)
  );

  pin_sync u_sync_peak (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(peak_trip_i),
    .sync_o (peak_s)
  );

  pin_sync u_sync_ovl (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(overload_guard_i),
    .sync_o (ovl_s)
  );

  pin_sync u_sync_ovp (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(over_volt_i),
    .sync_o (ovp_s)
  );

  pin_sync u_sync_low_supply_lockout (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(low_supply_lockout_i),
    .sync_o (low_supply_lockout_s)
  );

  pin_sync u_sync_otp (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(over_temp_i),
    .sync_o (otp_s)
  );

  // Enable low for the shutdown time
  hold_timer u_en_off (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(~en_s),
    .limit_i(EN_OFF_LIM),
    .done_o (en_low_long)
  );

  // Overload persistence; timer only armed after the ramp
  hold_timer u_ovl (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(ovl_s & ramp_done_o),                    // see R09
    .limit_i(OVL_LIM),
    .done_o (ovl_long)
  );

  // Faults that hold both switches off; only lockout also leaves ramp and run
  wire hold_off = low_supply_lockout_s | otp_s | ovp_s;             // see R07 see R10 see R12

  // Next-state decode
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (en_s && !low_supply_lockout_s) begin
          next_state = ST_RAMP;                       // see R04 see R17
        end
      end
      ST_RAMP: begin
        if (en_low_long || low_supply_lockout_s) begin
          next_state = ST_OFF;                        // see R06
        end else if (current_limit_step_o == `STEP_FULL &&
                     dwell_end(step_cnt, STEP_LIM)) begin
          next_state = ST_RUN;                        // see R05
        end
      end
      ST_RUN: begin
        if (en_low_long || low_supply_lockout_s) begin
          next_state = ST_OFF;                        // see R06 see R07
        end else if (ovl_long) begin
          next_state = ST_LATCH;                      // see R08
        end
      end
      ST_LATCH: begin
        // Needs the fault gone and a low-then-high enable
        if (!ovl_s && en_s && en_seen_low) begin
          next_state = ST_RAMP;                       // see R08
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // State register and enable-toggle tracking for the latch
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= ST_OFF;
      en_seen_low <= 1'b0;
    end else begin
      state <= next_state;
      if (state != ST_LATCH) begin
        en_seen_low <= 1'b0;
      end else if (!en_s) begin
        en_seen_low <= 1'b1;
      end
    end
  end

  // Soft-start ramp: step count and per-step dwell
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_limit_step_o <= `STEP_NONE;
      step_cnt             <= {`CNT_W{1'b0}};
      ramp_done_o          <= 1'b0;
    end else if (next_state == ST_OFF || next_state == ST_LATCH) begin
      current_limit_step_o <= `STEP_NONE;             // see R18
      step_cnt             <= {`CNT_W{1'b0}};
      ramp_done_o          <= 1'b0;
    end else if (next_state == ST_RUN) begin
      current_limit_step_o <= `STEP_FULL;
      ramp_done_o          <= 1'b1;
    end else if (state != ST_RAMP) begin
      current_limit_step_o <= `STEP_MIN;              // see R05 see R18
      step_cnt             <= {`CNT_W{1'b0}};
    end else if (dwell_end(step_cnt, STEP_LIM)) begin
      current_limit_step_o <= current_limit_step_o + `STEP_MIN;  // see R05
      step_cnt             <= {`CNT_W{1'b0}};
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end

  // Regulation runs through the ramp and the run states
  wire active = (state == ST_RAMP || state == ST_RUN);  // see R04

  // Switching phase counter, free-running while regulating
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase         <= {`PER_W{1'b0}};
      cycle_start_o <= 1'b0;
    end else if (!active || cycle_end(phase)) begin
      phase         <= {`PER_W{1'b0}};
      cycle_start_o <= active;                        // see R01
    end else begin
      phase         <= phase + 5'h01;
      cycle_start_o <= 1'b0;
    end
  end

  // Per-cycle on window; peak trip ends it until the next cycle start
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_allowed <= 1'b0;
    end else if (!active) begin
      on_allowed <= 1'b0;
    end else if (cycle_end(phase)) begin
      on_allowed <= 1'b1;                             // see R01
    end else if (peak_s || phase >= ON_LAST) begin
      on_allowed <= 1'b0;                             // see R02 see R13
    end
  end

  // Next switch levels; every fault gates both switches ahead of the flops
  always @* begin
    next_power = 1'b0;
    next_iso   = 1'b0;
    if (active && !hold_off && !ovl_long) begin       // see R10 see R11
      next_power = cycle_end(phase) ||                // see R01
                   (on_allowed && !peak_s && phase < ON_LAST);  // see R02 see R13
      next_iso   = dim_s;                             // see R03
    end
  end

  // Switch flops; the extra stage keeps both gates free of glitches
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_switch_o <= 1'b0;
      iso_switch_o   <= 1'b0;
    end else begin
      power_switch_o <= next_power;
      // Two sync flops plus this one: 150 ns, well inside 1 us
      iso_switch_o   <= next_iso;                     // see R03
    end
  end

  // Shutdown flag for the low-power mode
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shutdown_o         <= 1'b1;
      overload_latched_o <= 1'b0;
    end else begin
      shutdown_o         <= (next_state == ST_OFF);   // see R06
      overload_latched_o <= (next_state == ST_LATCH);
    end
  end
endmodule

// ===== sim/led_boost_monitor.sv
// Port checker bound onto the boost sequencer
`timescale 1ns/1ps
module led_boost_monitor (
  input wire mclk_i,
  input wire rst_n_i,
  input wire dim_i,
  input wire peak_trip_i,
  input wire over_volt_i,
  input wire low_supply_lockout_i,
  input wire over_temp_i,
  input wire power_switch_o,
  input wire iso_switch_o,
  input wire ramp_done_o,
  input wire overload_latched_o,
  input wire shutdown_o,
  input wire cycle_start_o
);
  // Holds of four or five cycles cover the input sync latency
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  lock_off_a: assert property (
    low_supply_lockout_i [*5] |-> !power_switch_o && !iso_switch_o)
    else $error("switch on in lockout");
  ovp_off_a: assert property (
    $rose(over_volt_i) |-> ##[1:4] !power_switch_o && !iso_switch_o)
    else $error("switch on after overvoltage");
  hot_off_a: assert property (
    over_temp_i [*5] |-> !(power_switch_o || iso_switch_o))
    else $error("switch on when hot");
  dim_off_a: assert property (!dim_i [*5] |-> !iso_switch_o)
    else $error("iso on with dim low");
  ovl_arm_a: assert property ($rose(overload_latched_o) |-> $past(ramp_done_o))
    else $error("latch before ramp done");
  cycle_period_a: assert property (cycle_start_o |=> !cycle_start_o [*8])
    else $error("period too short");
  trip_off_a: assert property (peak_trip_i [*4] |-> ##[0:1] !power_switch_o)
    else $error("switch on after trip");
  shut_off_a: assert property (shutdown_o [*2] |-> !power_switch_o && !iso_switch_o)
    else $error("switch on in shutdown");
endmodule
bind led_boost_sequencer led_boost_monitor i_mon (.mclk_i, .rst_n_i, .dim_i, .peak_trip_i,
  .over_volt_i, .low_supply_lockout_i, .over_temp_i, .power_switch_o, .iso_switch_o,
  .ramp_done_o, .overload_latched_o, .shutdown_o, .cycle_start_o);

// ===== sim/host_model.sv
// Host model driving the enable and dimming pins
`timescale 1ns/1ps
module host_model (
  input  wire mclk_i,
  output reg  enable_o,
  output reg  dim_o
);
  initial begin
    enable_o = 1'h0;
    dim_o    = 1'h1;
  end
  // Low phase of n cycles, n at least 100; with the 400-cycle high phase this keeps
  // the dimming period at 25 us or more, inside the 40 kHz limit
  task dim_low(input integer n);
    begin
      @(posedge mclk_i) dim_o <= 1'h0;
      repeat (n) @(posedge mclk_i);
      dim_o <= 1'h1;
      repeat (400) @(posedge mclk_i);
    end
  endtask
  task set_en(input reg v);
    @(posedge mclk_i) enable_o <= v;
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the boost sequencer
`timescale 1ns/1ps
module tb_top;
  reg        mclk, rst_n, peak, ovl, ovv, lock, hot;
  wire       en, dim, pwr, iso, done, latched, sd, cs;
  wire [3:0] step;
  integer    fails, tests_run, k, n, m;

  host_model i_host (.mclk_i(mclk), .enable_o(en), .dim_o(dim));
  led_boost_sequencer i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .enable_i(en), .dim_i(dim),
    .peak_trip_i(peak), .overload_guard_i(ovl), .over_volt_i(ovv),
    .low_supply_lockout_i(lock), .over_temp_i(hot), .power_switch_o(pwr),
    .iso_switch_o(iso), .current_limit_step_o(step), .ramp_done_o(done),
    .overload_latched_o(latched), .shutdown_o(sd), .cycle_start_o(cs));

  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  task complete_run;
    begin
      if (fails == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input string what, input [3:0] seen, input [3:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Sample 1 ns after the edge so its updates have landed
  task tick(input integer c);
    repeat (c) #1 @(posedge mclk) #1;
  endtask
  task count(input integer c);
    begin
      n = 0;
      m = 0;
      repeat (c) begin
        tick(1);
        n = n + pwr;
        m = m + cs;
      end
    end
  endtask
  task toggle;
    begin
      i_host.set_en(1'h0);
      tick(50);
      i_host.set_en(1'h1);
      tick(10);
    end
  endtask
  // Ramp of 4260-cycle steps, with an overload held in step 3
  task t_ramp;
    begin
      check("sd_reset", sd, 4'h1);
      i_host.set_en(1'h1);
      for (k = 0; step !== 4'h1 && k < 20; k = k + 1) tick(1);
      check("step_first", step, 4'h1);
      for (k = 2; k <= 8; k = k + 1) begin
        tick(4258);
        @(posedge mclk) ovl <= (k == 3);
        #1;
        check("step_hold", step, k - 1);
        tick(1);
        check("step_next", step, k);
        check("ovl_ignored", latched, 4'h0);
      end
      for (k = 0; done !== 1'h1 && k < 4300; k = k + 1) tick(1);
      check("ramp_len", k > 4250 && k < 4270, 4'h1);
    end
  endtask
  task t_run;
    begin
      count(160);
      check("starts", m == 10, 4'h1);
      check("on_time", n >= 144, 4'h1);
      fork
        i_host.dim_low(100);
        begin
          tick(30);
          check("iso_low", iso, 4'h0);
        end
      join
      check("iso_high", iso, 4'h1);
      @(posedge mclk) peak <= 1'h1;
      tick(5);
      count(32);
      check("trip_on", n <= 4, 4'h1);
      @(posedge mclk) peak <= 1'h0;
    end
  endtask
  // Overvoltage then heat; switching must come back on release
  task t_prot;
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge mclk) {ovv, hot} <= (k == 0) ? 2'h2 : 2'h1;
      tick(20);
      count(16);
      check("fault_off", n + iso == 0, 4'h1);
      @(posedge mclk) {ovv, hot} <= 2'h0;
      tick(20);
      count(32);
      check("resume", n > 0 && iso, 4'h1);
    end
  endtask
  task t_latch;
    begin
      @(posedge mclk) ovl <= 1'h1;
      tick(40);
      count(16);
      check("latch_on", latched && n + iso == 0, 4'h1);
      toggle;
      check("latch_kept", latched, 4'h1);
      @(posedge mclk) ovl <= 1'h0;
      toggle;
      check("latch_clr", latched, 4'h0);
      check("ramp_again", step, 4'h1);
    end
  endtask
  // Lockout mid-ramp restarts at step 1; a 1 ms enable low shuts down
  task t_off;
    begin
      tick(4300);
      check("pre_lock", step, 4'h2);
      @(posedge mclk) lock <= 1'h1;
      tick(20);
      count(16);
      check("lock_off", n + iso == 0, 4'h1);
      @(posedge mclk) lock <= 1'h0;
      tick(20);
      check("lock_ramp", step, 4'h1);
      i_host.set_en(1'h0);
      tick(19990);
      check("sd_early", sd, 4'h0);
      tick(30);
      check("sd_late", sd, 4'h1);
    end
  endtask
  initial begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'h0;
    {peak, ovl, ovv, lock, hot} = 5'h00;
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    tick(2);
    t_ramp;
    t_run;
    t_prot;
    t_latch;
    t_off;
    complete_run;
  end
  // Run needs about 60k cycles; cut off at 100k
  initial begin
    #5000000;
    fails = fails + 1;
    complete_run;
  end
endmodule
